/* File: src/emb_bus.sv */
// External memory bus interface: strobes, waits, overlap routing and hold
//
// Overview of operation
// - Low ready input stretches cycle one to three in wait mode 10; mode 11 stalls while it stays low
// - Wait count 01 adds exactly one cycle
// - Strobe stays low through every wait cycle
// - Port three address reads external in expansion
// - Port three write updates latch, and external in expansion
// - Overlapped address: internal memory is valid
// - Overlap read: internal data, external strobe still
// - Overlap write: internal and external both written
// - Read strobe on reads, write strobe on writes
// - Strobes also for internal accesses in expansion
// - Buffer-full output enabled disables hold acknowledge
// - Waits only for external accesses in expansion
// - No waits at addresses 0008 through 000F
// - Mode write switches expansion for next access, ROM window at once
// - Ready tied low waits every eligible cycle
// - Wait mode 00 selects fixed software wait
// - Wait mode 10 selects ready-input wait
// - Internal accesses never wait
// - Mode 01 selects expansion, internal ROM valid
//
// The register offsets and the strobed register port were decided locally.
`timescale 1ns/1ps
`default_nettype none

module emb_bus
(
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    input  wire logic        cpu_req,
    input  wire logic        cpu_we,
    input  wire logic [15:0] cpu_addr,
    input  wire logic [7:0]  cpu_wdata,
    output logic             cpu_ready,
    output logic      [7:0]  cpu_rdata,
    output logic      [15:0] int_addr,
    output logic      [7:0]  int_wdata,
    output logic             int_we,
    input  wire logic [7:0]  int_rdata,
    output logic      [15:0] ext_addr,
    output logic             ext_addr_oe,
    output logic      [7:0]  ext_data_out,
    output logic             ext_data_oe,
    input  wire logic [7:0]  ext_data_in,
    output logic             rd_n,
    output logic             wr_n,
    input  wire logic        rdy_n,
    input  wire logic        hold_n,
    output logic             hold_acknowledge_out_n,
    output logic             host_input_buffer_full_out_en,
    output logic      [7:0]  port_three_latch
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations

    logic [1:0]            mode;
    logic [1:0]            next_mode;
    emb_pkg::emb_wait_cfg_s wait_cfg;
    emb_pkg::emb_wait_cfg_s next_wait_cfg;
    logic                  ibf_en;
    logic                  next_ibf_en;
    logic [7:0]            next_port_three_latch;
    logic [7:0]            next_reg_rdata;

    emb_pkg::emb_state_e   state;
    emb_pkg::emb_state_e   next_state;
    emb_pkg::emb_cpu_req_s req;
    emb_pkg::emb_cpu_req_s next_req;
    logic [1:0]            wait_left;
    logic [1:0]            next_wait_left;
    logic [7:0]            next_cpu_rdata;
    logic                  req_ext_mode;
    logic                  next_req_ext_mode;

    logic                  ext_mode;
    logic                  int_hit;
    logic                  nowait_hit;
    logic                  wait_ok;
    logic                  finish;
    logic                  p3_write;
    logic                  strobe;

    ////////////////////////////////////////////////////////////////////////
    // Address decode of the latched request

    // Expansion is sampled at acceptance, so it changes next access; the ROM window uses the live mode
    assign ext_mode   = (mode == emb_pkg::MODE_EXPAND) || (mode == emb_pkg::MODE_MICRO);
    // Internal area wins where both exist; ROM drops out in microprocessor mode
    assign int_hit    = !req_ext_mode
                      || (req.addr <= emb_pkg::SFR_HI
                          && !(req.addr >= emb_pkg::NOWAIT_LO && req.addr <= emb_pkg::NOWAIT_HI))
                      || (req.addr >= emb_pkg::RAM_LO && req.addr <= emb_pkg::RAM_HI)
                      || (req.addr >= emb_pkg::ROM_LO && mode != emb_pkg::MODE_MICRO);
    assign nowait_hit = req.addr >= emb_pkg::NOWAIT_LO && req.addr <= emb_pkg::NOWAIT_HI;
    // Waits only for true external area in expansion modes
    assign wait_ok    = req_ext_mode && !int_hit && !nowait_hit;
    assign finish     = cpu_ready;
    assign p3_write   = finish && req.we && req.addr == emb_pkg::P3_ADDR;
    assign strobe     = req_ext_mode
                      && (state == emb_pkg::ST_ACCESS || state == emb_pkg::ST_WAIT
                          || state == emb_pkg::ST_STALL);

    ////////////////////////////////////////////////////////////////////////
    // Register file next values

    always_comb
    begin
        next_mode             = mode;
        next_wait_cfg         = wait_cfg;
        next_ibf_en           = ibf_en;
        next_port_three_latch = port_three_latch;
        next_reg_rdata        = 8'h00;
        if (reg_wr)
        begin
            unique case (reg_addr)
                emb_pkg::REG_MODE:  next_mode     = reg_wdata[1:0];
                emb_pkg::REG_WAIT:  next_wait_cfg = reg_wdata;
                emb_pkg::REG_HOST:  next_ibf_en   = reg_wdata[0];
                emb_pkg::REG_PORT3: next_port_three_latch = reg_wdata;
                default:            next_mode     = mode;
            endcase
        end
        // Port three writes from the CPU always reach the latch
        if (p3_write)
            next_port_three_latch = req.wdata;
        if (reg_rd)
        begin
            unique case (reg_addr)
                emb_pkg::REG_MODE:  next_reg_rdata = {6'h00, mode};
                emb_pkg::REG_WAIT:  next_reg_rdata = wait_cfg;
                emb_pkg::REG_HOST:  next_reg_rdata = {7'h00, ibf_en};
                emb_pkg::REG_STAT:  next_reg_rdata = {3'h0, wait_left, state};
                emb_pkg::REG_PORT3: next_reg_rdata = port_three_latch;
                default:            next_reg_rdata = 8'h00;
            endcase
        end
    end

    // Register file flops
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mode             <= emb_pkg::RST_MODE[1:0];
            wait_cfg         <= emb_pkg::RST_WAIT;
            ibf_en           <= emb_pkg::RST_HOST[0];
            port_three_latch <= emb_pkg::RST_PORT3;
            reg_rdata        <= 8'h00;
        end
        else
        begin
            mode             <= next_mode;
            wait_cfg         <= next_wait_cfg;
            ibf_en           <= next_ibf_en;
            port_three_latch <= next_port_three_latch;
            reg_rdata        <= next_reg_rdata;
        end
    end

    assign host_input_buffer_full_out_en = ibf_en;

    ////////////////////////////////////////////////////////////////////////
    // Bus cycle sequencer next values

    always_comb
    begin
        next_state        = state;
        next_req          = req;
        next_req_ext_mode = req_ext_mode;
        next_wait_left    = wait_left;
        next_cpu_rdata    = cpu_rdata;
        cpu_ready         = 1'b0;
        unique case (state)
            emb_pkg::ST_IDLE:
            begin
                // Hold has priority over a waiting request
                if (ext_mode && wait_cfg.hold_en && !hold_n)
                    next_state = emb_pkg::ST_HOLD;
                else if (cpu_req)
                begin
                    next_req          = '{we: cpu_we, addr: cpu_addr, wdata: cpu_wdata};
                    next_req_ext_mode = ext_mode;
                    next_state        = emb_pkg::ST_ACCESS;
                end
            end
            emb_pkg::ST_ACCESS:
            begin
                // Ready is judged in the first strobe cycle, and again in each stall cycle of extended ready mode
                if (wait_ok && wait_cfg.wait_mode == emb_pkg::WM_RDY_EXT && !rdy_n)
                    next_state = emb_pkg::ST_STALL;
                else if (wait_ok && wait_cfg.wait_cnt != 2'h0
                         && (wait_cfg.wait_mode == emb_pkg::WM_SOFT
                             || wait_cfg.wait_mode == emb_pkg::WM_RDY_EXT
                             || (wait_cfg.wait_mode == emb_pkg::WM_RDY && !rdy_n)))
                begin
                    next_wait_left = wait_cfg.wait_cnt;
                    next_state     = emb_pkg::ST_WAIT;
                end
                else
                    cpu_ready = 1'b1;
            end
            emb_pkg::ST_STALL:
            begin
                // Extended ready mode keeps stretching while ready is low
                if (rdy_n && wait_cfg.wait_cnt == 2'h0)
                    cpu_ready = 1'b1;
                else if (rdy_n)
                begin
                    next_wait_left = wait_cfg.wait_cnt;
                    next_state     = emb_pkg::ST_WAIT;
                end
            end
            emb_pkg::ST_WAIT:
            begin
                // Ready pulses here are ignored: no re-extension late in the cycle
                if (wait_left == 2'h1)
                    cpu_ready = 1'b1;
                next_wait_left = wait_left - 2'h1;
            end
            emb_pkg::ST_HOLD:
                if (hold_n)
                    next_state = emb_pkg::ST_IDLE;
            default:
                next_state = emb_pkg::ST_IDLE;
        endcase
        if (cpu_ready)
        begin
            next_state = emb_pkg::ST_IDLE;
            // Port three reads the latch only in single-chip mode
            if (!req_ext_mode && req.addr == emb_pkg::P3_ADDR)
                next_cpu_rdata = port_three_latch;
            else if (int_hit)
                next_cpu_rdata = int_rdata;
            else
                next_cpu_rdata = ext_data_in;
        end
    end

    // Sequencer flops
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state        <= emb_pkg::ST_IDLE;
            req          <= '0;
            req_ext_mode <= 1'b0;
            wait_left    <= 2'h0;
            cpu_rdata    <= 8'h00;
        end
        else
        begin
            state        <= next_state;
            req          <= next_req;
            req_ext_mode <= next_req_ext_mode;
            wait_left    <= next_wait_left;
            cpu_rdata    <= next_cpu_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin drive; internal write happens alongside the external one

    assign int_addr     = req.addr;
    assign int_wdata    = req.wdata;
    assign int_we       = finish && req.we && int_hit;
    assign ext_addr     = req.addr;
    assign ext_addr_oe  = req_ext_mode && state != emb_pkg::ST_HOLD;
    assign ext_data_out = req.wdata;
    assign ext_data_oe  = strobe && req.we;
    // Strobes for every access in expansion modes, held through waits
    assign rd_n = !(strobe && !req.we);
    assign wr_n = !(strobe && req.we);
    // Acknowledge is muted while the host buffer-full output is enabled
    assign hold_acknowledge_out_n = !(state == emb_pkg::ST_HOLD && !ibf_en);

    ////////////////////////////////////////////////////////////////////////
    // Checks

    sequence s_rdy_start;
        state == emb_pkg::ST_ACCESS && wait_ok && !rdy_n
        && wait_cfg.wait_mode == emb_pkg::WM_RDY && wait_cfg.wait_cnt == 2'h1;
    endsequence

    sequence s_one_wait;
        (!cpu_ready && (!rd_n || !wr_n)) ##1 (cpu_ready && (!rd_n || !wr_n));
    endsequence

    AST_RDY_ONE_WAIT: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_rdy_start |-> s_one_wait)
        else $error("one-cycle ready wait not exactly one cycle");

    AST_RDY_BOUND: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state == emb_pkg::ST_ACCESS && wait_cfg.wait_mode == emb_pkg::WM_RDY)
        |-> ##[0:3] cpu_ready)
        else $error("ready wait longer than three cycles");

    AST_STROBE_HELD: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state == emb_pkg::ST_WAIT && req_ext_mode) |-> (rd_n != wr_n))
        else $error("strobe released during wait");

    AST_NOWAIT_LOW: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state == emb_pkg::ST_ACCESS && nowait_hit) |-> cpu_ready)
        else $error("wait inserted at 0008..000F");

    AST_INT_NOWAIT: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state == emb_pkg::ST_ACCESS && int_hit) |-> cpu_ready)
        else $error("wait inserted on internal access");

    AST_HOLD_MUTED: assert property (@(posedge core_clk) disable iff (!rst_n)
        ibf_en |-> hold_acknowledge_out_n)
        else $error("hold acknowledge active with buffer-full output");

    AST_P3_BOTH: assert property (@(posedge core_clk) disable iff (!rst_n)
        (p3_write && req_ext_mode) |-> !wr_n ##1 (port_three_latch == $past(req.wdata)))
        else $error("port three write missed latch or bus");

    AST_OVL_READ: assert property (@(posedge core_clk) disable iff (!rst_n)
        (finish && !req.we && int_hit && req_ext_mode)
        |-> !rd_n ##1 (cpu_rdata == $past(int_rdata)))
        else $error("overlap read not internal or no strobe");

    AST_P3_READ_EXT: assert property (@(posedge core_clk) disable iff (!rst_n)
        (finish && !req.we && req_ext_mode && req.addr == emb_pkg::P3_ADDR)
        |=> (cpu_rdata == $past(ext_data_in)))
        else $error("port three read not from external bus");

    AST_SINGLE_QUIET: assert property (@(posedge core_clk) disable iff (!rst_n)
        !req_ext_mode |-> (rd_n && wr_n))
        else $error("strobe in single-chip mode");

endmodule

`default_nettype wire

/* File: src/emb_pkg.sv */
// Shared constants, types and register map of the external memory bus block
package emb_pkg;

    // Register port offsets
    localparam logic [3:0] REG_MODE  = 4'h0;
    localparam logic [3:0] REG_WAIT  = 4'h1;
    localparam logic [3:0] REG_HOST  = 4'h2;
    localparam logic [3:0] REG_STAT  = 4'h3;
    localparam logic [3:0] REG_PORT3 = 4'h4;

    // Processor mode codes
    localparam logic [1:0] MODE_SINGLE = 2'h0;
    localparam logic [1:0] MODE_EXPAND = 2'h1;
    localparam logic [1:0] MODE_MICRO  = 2'h2;

    // Slow memory wait mode codes
    localparam logic [1:0] WM_SOFT    = 2'h0;
    localparam logic [1:0] WM_RDY     = 2'h2;
    localparam logic [1:0] WM_RDY_EXT = 2'h3;

    // Values after reset
    localparam logic [7:0] RST_MODE  = 8'h00;
    localparam logic [7:0] RST_WAIT  = 8'h00;
    localparam logic [7:0] RST_HOST  = 8'h00;
    localparam logic [7:0] RST_PORT3 = 8'h00;

    // CPU address map
    localparam logic [15:0] P3_ADDR   = 16'h000e;
    localparam logic [15:0] NOWAIT_LO = 16'h0008;
    localparam logic [15:0] NOWAIT_HI = 16'h000f;
    localparam logic [15:0] SFR_HI    = 16'h003f;
    localparam logic [15:0] RAM_LO    = 16'h0040;
    localparam logic [15:0] RAM_HI    = 16'h0fff;
    localparam logic [15:0] ROM_LO    = 16'h8000;

    // Core clock period in ns, base bus cycle length in core_clk cycles
    localparam int CLK_PERIOD_NS = 25;
    localparam int BASE_CYCLES   = 1;

    // Wait configuration layout
    typedef struct packed {
        logic [1:0] spare;
        logic       hold_en;
        logic       spare4;
        logic [1:0] wait_mode;
        logic [1:0] wait_cnt;
    } emb_wait_cfg_s;

    // Latched CPU request
    typedef struct packed {
        logic        we;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } emb_cpu_req_s;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_ACCESS = 3'b001,
        ST_WAIT   = 3'b010,
        ST_STALL  = 3'b011,
        ST_HOLD   = 3'b100
    } emb_state_e;

endpackage

/* File: verif/emb_mem_model.sv */
// External ROM and SRAM model on the far side of the bus block
`timescale 1ns/1ps
`default_nettype none

module emb_mem_model
(
    input  wire logic        core_clk,
    input  wire logic [15:0] ext_addr,
    input  wire logic [7:0]  ext_data_out,
    input  wire logic        ext_data_oe,
    input  wire logic        rd_n,
    input  wire logic        wr_n,
    input  wire logic        slow,
    input  wire logic        tied,
    output logic      [7:0]  ext_data_in,
    output logic             rdy_n
);
    logic [7:0] mem [0:255];
    logic [7:0] last;

    // Known contents, distinct from the internal pattern
    initial
    begin
        for (int i = 0; i < 256; i++)
            mem[i] = 8'(i) ^ 8'ha3;
        last = 8'h00;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Store under the write strobe, remember the last value driven out
    always @(posedge core_clk)
    begin
        if (!wr_n && ext_data_oe)
            mem[ext_addr[7:0]] <= ext_data_out;
        if (!rd_n)
            last <= mem[ext_addr[7:0]];
    end

    // Released bus shows the inverse, so stale data can never look right
    assign ext_data_in = !rd_n ? mem[ext_addr[7:0]] : ~last;
    // Slow part pulls ready low in its strobe; a strap holds it low always
    assign rdy_n = tied ? 1'b0 : !(slow && !(rd_n && wr_n));
endmodule
`default_nettype wire

/* File: verif/tb_emb_bus.sv */
// Self-checking testbench of the external memory bus block
`timescale 1ns/1ps
`default_nettype none

module tb_emb_bus;
    logic        core_clk;
    logic        rst_n;
    logic [3:0]  reg_addr;
    logic [7:0]  reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [7:0]  reg_rdata;
    logic        cpu_req;
    logic        cpu_we;
    logic [15:0] cpu_addr;
    logic [7:0]  cpu_wdata;
    logic        cpu_ready;
    logic [7:0]  cpu_rdata;
    logic [15:0] int_addr;
    logic [7:0]  int_wdata;
    logic [7:0]  int_rdata;
    logic        int_we;
    logic [15:0] ext_addr;
    logic        ext_addr_oe;
    logic [7:0]  ext_data_out;
    logic        ext_data_oe;
    logic [7:0]  ext_data_in;
    logic        rd_n;
    logic        wr_n;
    logic        rdy_n;
    logic        hold_n;
    logic        ack_n;
    logic        ibf_en;
    logic [7:0]  p3;
    logic        slow;
    logic        tied;
    logic [15:0] lat;
    logic [15:0] lowc;
    logic [15:0] we_cnt;
    logic [7:0]  rdv;
    int          bad_count;
    int          checks_done;
    int          cyc;

    emb_bus dut_u
    (
        .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .cpu_req(cpu_req), .cpu_we(cpu_we),
        .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_ready(cpu_ready),
        .cpu_rdata(cpu_rdata), .int_addr(int_addr), .int_wdata(int_wdata),
        .int_we(int_we), .int_rdata(int_rdata), .ext_addr(ext_addr),
        .ext_addr_oe(ext_addr_oe), .ext_data_out(ext_data_out),
        .ext_data_oe(ext_data_oe), .ext_data_in(ext_data_in), .rd_n(rd_n),
        .wr_n(wr_n), .rdy_n(rdy_n), .hold_n(hold_n),
        .hold_acknowledge_out_n(ack_n), .host_input_buffer_full_out_en(ibf_en),
        .port_three_latch(p3)
    );

    emb_mem_model mem_u
    (
        .core_clk(core_clk), .ext_addr(ext_addr), .ext_data_out(ext_data_out),
        .ext_data_oe(ext_data_oe), .rd_n(rd_n), .wr_n(wr_n), .slow(slow),
        .tied(tied), .ext_data_in(ext_data_in), .rdy_n(rdy_n)
    );

    // Internal memory answers with its own pattern
    assign int_rdata = int_addr[7:0] ^ 8'h5a;

    ////////////////////////////////////////////////////////////////////////////
    // Clock, hang guard and internal write counter
    always #12.5 core_clk = ~core_clk;

    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            bad_count++;
            print_verdict();
        end
    end

    always @(negedge core_clk)
        if (int_we === 1'b1)
            we_cnt = we_cnt + 16'h1;

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic reg_w(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic reg_chk(input logic [3:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(negedge core_clk);
        chk(reg_rdata, exp);
    endtask

    // Request held until ready; counts cycles and strobe-low cycles
    task automatic cpu_acc(input logic we, input logic [15:0] a, input logic [7:0] d);
        @(posedge core_clk);
        cpu_req   <= 1'b1;
        cpu_we    <= we;
        cpu_addr  <= a;
        cpu_wdata <= d;
        lat  = 16'h0;
        lowc = 16'h0;
        @(posedge core_clk);
        do
        begin
            @(negedge core_clk);
            lat = lat + 16'h1;
            if ((we ? wr_n : rd_n) === 1'b0)
                lowc = lowc + 16'h1;
        end while (cpu_ready !== 1'b1 && lat < 16'h14);
        @(posedge core_clk);
        cpu_req <= 1'b0;
        @(negedge core_clk);
        rdv = cpu_rdata;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        reg_chk(emb_pkg::REG_MODE, emb_pkg::RST_MODE);
        reg_chk(emb_pkg::REG_WAIT, emb_pkg::RST_WAIT);
        reg_chk(emb_pkg::REG_HOST, emb_pkg::RST_HOST);
        reg_chk(emb_pkg::REG_PORT3, emb_pkg::RST_PORT3);
        reg_chk(4'h7, 8'h00);
        reg_w(emb_pkg::REG_STAT, 8'hff);
        reg_chk(emb_pkg::REG_STAT, 8'h00);
        reg_w(emb_pkg::REG_WAIT, 8'h09);
        reg_chk(emb_pkg::REG_WAIT, 8'h09);
        $display("test regs done");
    endtask

    task automatic t_single();
        reg_w(emb_pkg::REG_WAIT, 8'h00);
        reg_w(emb_pkg::REG_PORT3, 8'h6c);
        cpu_acc(1'b0, emb_pkg::P3_ADDR, 8'h00);
        chk(rdv, 8'h6c);
        chk(lowc, 16'h0);
        $display("test single done");
    endtask

    task automatic t_expand();
        logic [15:0] n;
        reg_w(emb_pkg::REG_MODE, {6'h00, emb_pkg::MODE_EXPAND});
        cpu_acc(1'b0, emb_pkg::RAM_LO, 8'h00);
        chk(rdv, 8'h1a);
        chk(lowc, 16'h1);
        cpu_acc(1'b0, emb_pkg::ROM_LO, 8'h00);
        chk(rdv, 8'h5a);
        n = we_cnt;
        cpu_acc(1'b1, 16'h0041, 8'h77);
        chk(we_cnt, n + 16'h1);
        chk(mem_u.mem[8'h41], 8'h77);
        chk(int_wdata, 8'h77);
        chk(lowc, 16'h1);
        $display("test expand done");
    endtask

    task automatic t_port3();
        cpu_acc(1'b1, emb_pkg::P3_ADDR, 8'ha5);
        chk(p3, 8'ha5);
        chk(mem_u.mem[8'h0e], 8'ha5);
        reg_w(emb_pkg::REG_PORT3, 8'h11);
        cpu_acc(1'b0, emb_pkg::P3_ADDR, 8'h00);
        chk(rdv, 8'ha5);
        $display("test port3 done");
    endtask

    task automatic t_waits();
        slow = 1'b1;
        for (int n = 1; n <= 3; n++)
        begin
            reg_w(emb_pkg::REG_WAIT, {4'h0, emb_pkg::WM_RDY, 2'(n)});
            cpu_acc(1'b0, 16'h2011, 8'h00);
            chk(lat, 16'(n + 1));
            chk(lowc, 16'(n + 1));
            chk(rdv, 8'hb2);
        end
        cpu_acc(1'b1, 16'h2012, 8'h3c);
        chk(lowc, 16'h4);
        reg_w(emb_pkg::REG_WAIT, 8'h09);
        cpu_acc(1'b0, emb_pkg::P3_ADDR, 8'h00);
        chk(lat, 16'h1);
        cpu_acc(1'b0, emb_pkg::NOWAIT_LO, 8'h00);
        chk(lat, 16'h1);
        cpu_acc(1'b0, emb_pkg::RAM_LO, 8'h00);
        chk(lat, 16'h1);
        reg_w(emb_pkg::REG_MODE, {6'h00, emb_pkg::MODE_SINGLE});
        cpu_acc(1'b0, 16'h2011, 8'h00);
        chk(lat, 16'h1);
        reg_w(emb_pkg::REG_MODE, {6'h00, emb_pkg::MODE_EXPAND});
        slow = 1'b0;
        cpu_acc(1'b0, 16'h2011, 8'h00);
        chk(lat, 16'h1);
        $display("test waits done");
    endtask

    task automatic t_soft_tied();
        reg_w(emb_pkg::REG_WAIT, 8'h02);
        cpu_acc(1'b1, 16'h2013, 8'h4d);
        chk(lat, 16'h3);
        chk(lowc, 16'h3);
        chk(mem_u.mem[8'h13], 8'h4d);
        reg_w(emb_pkg::REG_WAIT, 8'h09);
        tied = 1'b1;
        cpu_acc(1'b0, 16'h2011, 8'h00);
        chk(lat, 16'h2);
        cpu_acc(1'b1, 16'h2014, 8'h21);
        chk(lat, 16'h2);
        tied = 1'b0;
        // Extended ready mode with ready high: only the counted wait
        reg_w(emb_pkg::REG_WAIT, 8'h0d);
        cpu_acc(1'b0, 16'h2011, 8'h00);
        chk(lat, 16'h2);
        chk(rdv, 8'hb2);
        $display("test soft and tied done");
    endtask

    task automatic t_hold();
        reg_w(emb_pkg::REG_WAIT, 8'h20);
        @(posedge core_clk);
        hold_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        @(negedge core_clk);
        chk(ack_n, 1'b0);
        chk(ext_addr_oe, 1'b0);
        reg_w(emb_pkg::REG_HOST, 8'h01);
        @(negedge core_clk);
        chk(ibf_en, 1'b1);
        chk(ack_n, 1'b1);
        @(posedge core_clk);
        hold_n <= 1'b1;
        reg_w(emb_pkg::REG_HOST, 8'h00);
        reg_w(emb_pkg::REG_WAIT, 8'h00);
        $display("test hold done");
    endtask

    task automatic t_mode();
        reg_w(emb_pkg::REG_MODE, {6'h00, emb_pkg::MODE_MICRO});
        cpu_acc(1'b0, emb_pkg::ROM_LO, 8'h00);
        chk(rdv, 8'ha3);
        reg_w(emb_pkg::REG_MODE, {6'h00, emb_pkg::MODE_EXPAND});
        cpu_acc(1'b0, emb_pkg::ROM_LO, 8'h00);
        chk(rdv, 8'h5a);
        $display("test mode done");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        core_clk = 1'b0;
        rst_n = 1'b0;
        {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
        {cpu_req, cpu_we, cpu_addr, cpu_wdata} = '0;
        {slow, tied} = 2'b00;
        hold_n = 1'b1;
        we_cnt = 16'h0;
        bad_count = 0;
        checks_done = 0;
        cyc = 0;
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        t_regs();
        t_single();
        t_expand();
        t_port3();
        t_waits();
        t_soft_tied();
        t_hold();
        t_mode();
        print_verdict();
    end
endmodule
`default_nettype wire
